/* rtl/pma_addr_map.sv */
// Program counter, vector selection, address wrap and high-endurance decode.
`timescale 1ns/10ps
module pma_addr_map #(
  parameter int WORDS = pma_pkg::LARGE_WORDS
) (
  // Clock and reset.
  input wire logic clock_in,
  input wire logic nrst_in,
  // Sequencing requests from the core.
  input wire logic step_in,
  input wire logic load_in,
  input wire logic [pma_pkg::CNT_W-1:0] load_addr_in,
  input wire logic irq_take_in,
  // Self-write port.
  input wire logic wr_en_in,
  input wire logic [pma_pkg::CNT_W-1:0] wr_addr_in,
  input wire logic [pma_pkg::WORD_W-1:0] wr_data_in,
  // Fetch results.
  output logic [pma_pkg::CNT_W-1:0] program_counter_out,
  output logic [$clog2(WORDS)-1:0] fetch_addr_out,
  output logic [pma_pkg::WORD_W-1:0] instr_out,
  output logic high_endurance_region_out
);
  localparam int AW = $clog2(WORDS);
  localparam logic [AW-1:0] LAST_ADDR = AW'(WORDS - 1);
  localparam logic [AW-1:0] ENDURE_START = AW'(WORDS - pma_pkg::ENDURE_WORDS);

  // -----------------------------------------------------------------
  // Elaboration checks
  // -----------------------------------------------------------------
  if (WORDS != pma_pkg::SMALL_WORDS && WORDS != pma_pkg::LARGE_WORDS) begin : g_bad_words
    $error("WORDS must be 256 or 512.");
  end
  if (WORDS > pma_pkg::ARCH_WORDS || AW > pma_pkg::CNT_W) begin : g_bad_span
    $error("Present words exceed the counter span.");
  end
  if (pma_pkg::ENDURE_WORDS >= WORDS) begin : g_bad_region
    $error("Endurance region must lie inside present memory.");
  end
  if (pma_pkg::ENDURE_BYTE_W >= pma_pkg::WORD_W) begin : g_bad_byte
    $error("Endurance byte must be narrower than a word.");
  end
  if ((1 << pma_pkg::CNT_W) != pma_pkg::ARCH_WORDS) begin : g_bad_arch
    $error("Counter width does not span the architectural space.");
  end

  logic [pma_pkg::CNT_W-1:0] program_counter;
  logic [pma_pkg::CNT_W-1:0] next_program_counter;
  logic [AW-1:0] next_addr;
  logic [AW-1:0] wr_word;
  logic wr_in_endure;
  logic wr_hi_en;

  // -----------------------------------------------------------------
  // Counter sequencing
  // -----------------------------------------------------------------
  always_comb begin
    if (!nrst_in) begin
      next_program_counter = pma_pkg::RESET_VECTOR;
    end else if (irq_take_in) begin
      next_program_counter = pma_pkg::IRQ_VECTOR;
    end else if (load_in) begin
      next_program_counter = load_addr_in;
    end else if (step_in) begin
      next_program_counter = program_counter + pma_pkg::CNT_STEP;
    end else begin
      next_program_counter = program_counter;
    end
  end

  always_ff @(posedge clock_in) begin
    program_counter <= next_program_counter;
  end

  assign program_counter_out = program_counter;

  // -----------------------------------------------------------------
  // Wrap and region decode
  // -----------------------------------------------------------------
  assign next_addr = next_program_counter[AW-1:0];

  always_ff @(posedge clock_in) begin
    fetch_addr_out <= next_addr;
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      high_endurance_region_out <= 1'b0;
    end else begin
      high_endurance_region_out <= (next_addr >= ENDURE_START);
    end
  end

  // -----------------------------------------------------------------
  // Program store
  // -----------------------------------------------------------------
  assign wr_word = wr_addr_in[AW-1:0];
  assign wr_in_endure = (wr_word >= ENDURE_START);
  assign wr_hi_en = wr_en_in && !wr_in_endure;

  pma_prog_mem #(
    .WORDS(WORDS),
    .AW(AW),
    .DW(pma_pkg::WORD_W),
    .LO_W(pma_pkg::ENDURE_BYTE_W)
  ) i_pma_prog_mem (
    .clock_in(clock_in),
    .rd_addr_in(next_addr),
    .rd_data_out(instr_out),
    .wr_addr_in(wr_word),
    .wr_data_in(wr_data_in),
    .wr_lo_in(wr_en_in),
    .wr_hi_in(wr_hi_en)
  );

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  sequence s_irq;
    irq_take_in;
  endsequence

  sequence s_load;
    load_in && !irq_take_in;
  endsequence

  sequence s_plain_step;
    step_in && !load_in && !irq_take_in;
  endsequence

  sequence s_idle;
    !step_in && !load_in && !irq_take_in;
  endsequence

  sequence s_at_last;
    program_counter_out[AW-1:0] == LAST_ADDR;
  endsequence

  sequence s_endure_write;
    wr_en_in && wr_in_endure;
  endsequence

  sequence s_reset_state;
    program_counter_out == pma_pkg::RESET_VECTOR && fetch_addr_out == '0
      && !high_endurance_region_out;
  endsequence

  property p_reset_vector;
    $rose(nrst_in) |-> program_counter_out == pma_pkg::RESET_VECTOR;
  endproperty

  property p_reset_clear;
    disable iff (1'b0) !nrst_in |=> s_reset_state;
  endproperty

  property p_irq_vector;
    s_irq |=> program_counter_out == pma_pkg::IRQ_VECTOR;
  endproperty

  property p_irq_fetch;
    s_irq |=> fetch_addr_out == AW'(pma_pkg::IRQ_VECTOR);
  endproperty

  property p_count_step;
    s_plain_step |=> program_counter_out == $past(program_counter_out) + pma_pkg::CNT_STEP;
  endproperty

  property p_count_hold;
    s_idle |=> program_counter_out == $past(program_counter_out);
  endproperty

  property p_load_jump;
    s_load |=> program_counter_out == $past(load_addr_in);
  endproperty

  property p_load_fetch;
    s_load |=> fetch_addr_out == AW'($past(load_addr_in));
  endproperty

  property p_wrap_modulo;
    s_plain_step ##0 s_at_last |=> fetch_addr_out == '0;
  endproperty

  property p_step_fetch;
    s_plain_step |=> fetch_addr_out == AW'($past(fetch_addr_out) + 1);
  endproperty

  property p_endure_decode;
    ##1 high_endurance_region_out == (fetch_addr_out >= ENDURE_START);
  endproperty

  property p_endure_first;
    fetch_addr_out == ENDURE_START |-> high_endurance_region_out;
  endproperty

  property p_endure_last;
    fetch_addr_out == LAST_ADDR |-> high_endurance_region_out;
  endproperty

  a_reset_vector: assert property (p_reset_vector)
    else $error("Counter not at reset vector after reset.");
  a_reset_clear: assert property (p_reset_clear)
    else $error("Outputs not cleared by reset.");
  a_irq_vector: assert property (p_irq_vector)
    else $error("Interrupt did not reach vector four.");
  a_irq_fetch: assert property (p_irq_fetch)
    else $error("Interrupt did not fetch from vector four.");
  a_count_step: assert property (p_count_step)
    else $error("Counter did not advance by one.");
  a_count_hold: assert property (p_count_hold)
    else $error("Counter moved without a request.");
  a_load_jump: assert property (p_load_jump)
    else $error("Counter did not take the loaded address.");
  a_load_fetch: assert property (p_load_fetch)
    else $error("Loaded address did not wrap into present memory.");
  a_addr_wrap: assert property (fetch_addr_out == program_counter_out[AW-1:0])
    else $error("Fetch address is not the wrapped counter.");
  a_addr_range: assert property (fetch_addr_out <= LAST_ADDR)
    else $error("Fetch address beyond last word.");
  a_wrap_modulo: assert property (p_wrap_modulo)
    else $error("Wrap past last word did not return to zero.");
  a_step_fetch: assert property (p_step_fetch)
    else $error("Fetch address did not step modulo the size.");
  a_endure_decode: assert property (p_endure_decode)
    else $error("Endurance flag disagrees with address.");
  a_endure_first: assert property (p_endure_first)
    else $error("First word of endurance region not flagged.");
  a_endure_last: assert property (p_endure_last)
    else $error("Last word not in endurance region.");
  a_endure_byte: assert property (s_endure_write |-> !wr_hi_en)
    else $error("Upper bits written inside endurance region.");
endmodule // pma_addr_map

/* rtl/pma_pkg.sv */
// Constants shared by the program memory address map block.
package pma_pkg;
  localparam int CNT_W = 13;
  localparam int WORD_W = 14;
  localparam int ARCH_WORDS = 8192;
  localparam int SMALL_WORDS = 256;
  localparam int LARGE_WORDS = 512;
  localparam int ENDURE_WORDS = 128;
  localparam int ENDURE_BYTE_W = 8;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [12:0] CNT_STEP = 13'h0001;
endpackage : pma_pkg

/* rtl/pma_prog_mem.sv */
// Program word store with a registered read port and split byte writes.
`timescale 1ns/10ps
module pma_prog_mem #(
  parameter int WORDS = 512,
  parameter int AW = 9,
  parameter int DW = 14,
  parameter int LO_W = 8
) (
  // Clock.
  input wire logic clock_in,
  // Read port.
  input wire logic [AW-1:0] rd_addr_in,
  output logic [DW-1:0] rd_data_out,
  // Write port.
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [DW-1:0] wr_data_in,
  input wire logic wr_lo_in,
  input wire logic wr_hi_in
);
  if (WORDS != (1 << AW) || LO_W < 1 || LO_W >= DW) begin : g_bad_shape
    $error("Memory shape parameters are inconsistent.");
  end

  logic [DW-1:0] mem [WORDS];

  always_ff @(posedge clock_in) begin
    if (wr_lo_in) begin
      mem[wr_addr_in][LO_W-1:0] <= wr_data_in[LO_W-1:0];
    end
    if (wr_hi_in) begin
      mem[wr_addr_in][DW-1:LO_W] <= wr_data_in[DW-1:LO_W];
    end
  end

  always_ff @(posedge clock_in) begin
    rd_data_out <= mem[rd_addr_in];
  end
endmodule // pma_prog_mem

/* verification/pma_addr_map_test.sv */
// Self-checking testbench for the program memory address map block.
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module pma_addr_map_test;
  logic clock_in, nrst_in, step_in, load_in, irq_take_in, wr_en_in, high_endurance_region_out;
  logic [12:0] load_addr_in, wr_addr_in, program_counter_out;
  logic [13:0] wr_data_in, instr_out;
  logic [8:0] fetch_addr_out;
  logic [5:0] hi_keep;
  logic [7:0] sm_fetch;
  logic sm_flag;
  int failures = 0;
  int samples_checked = 0;
  pma_addr_map #(.WORDS(512)) i_pma_addr_map (.clock_in(clock_in), .nrst_in(nrst_in),
    .step_in(step_in), .load_in(load_in), .load_addr_in(load_addr_in),
    .irq_take_in(irq_take_in), .wr_en_in(wr_en_in), .wr_addr_in(wr_addr_in),
    .wr_data_in(wr_data_in), .program_counter_out(program_counter_out),
    .fetch_addr_out(fetch_addr_out), .instr_out(instr_out),
    .high_endurance_region_out(high_endurance_region_out));
  pma_addr_map #(.WORDS(256)) i_pma_addr_map_small (.clock_in(clock_in), .nrst_in(nrst_in),
    .step_in(step_in), .load_in(load_in), .load_addr_in(load_addr_in),
    .irq_take_in(irq_take_in), .wr_en_in(wr_en_in), .wr_addr_in(wr_addr_in),
    .wr_data_in(wr_data_in), .program_counter_out(), .fetch_addr_out(sm_fetch),
    .instr_out(), .high_endurance_region_out(sm_flag));
  // ----------------------------------------
  // Clock, drivers and report.
  // ----------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  task automatic tick();
    @(posedge clock_in);
    #1;
  endtask
  task automatic req(input logic irq, input logic ld, input logic st, input logic [12:0] a);
    irq_take_in = irq;
    load_in = ld;
    step_in = st;
    load_addr_in = a;
    wr_en_in = 1'b0;
    tick();
  endtask
  task automatic wr(input logic [12:0] a, input logic [13:0] d);
    {irq_take_in, load_in, step_in} = 3'h0;
    wr_en_in = 1'b1;
    wr_addr_in = a;
    wr_data_in = d;
    tick();
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  task automatic test_reset();
    req(1'b0, 1'b1, 1'b0, 13'h0055);
    nrst_in = 1'b0;
    tick();
    nrst_in = 1'b1;
    `CHK(program_counter_out, 13'h0000)
    `CHK(fetch_addr_out, 9'h000)
    req(1'b0, 1'b0, 1'b1, 13'h0000);
    `CHK(program_counter_out, 13'h0001)
  endtask
  task automatic test_wrap();
    req(1'b0, 1'b1, 1'b0, 13'h01FF);
    `CHK({fetch_addr_out, high_endurance_region_out}, {9'h1FF, 1'b1})
    `CHK({sm_fetch, sm_flag}, {8'hFF, 1'b1})
    req(1'b0, 1'b0, 1'b1, 13'h0000);
    `CHK({program_counter_out, fetch_addr_out}, {13'h0200, 9'h000})
    `CHK({sm_fetch, sm_flag}, {8'h00, 1'b0})
    req(1'b0, 1'b1, 1'b0, 13'h1ABC);
    `CHK(fetch_addr_out, 9'h0BC)
    req(1'b0, 1'b1, 1'b0, 13'h1FFF);
    req(1'b0, 1'b0, 1'b1, 13'h0000);
    `CHK(program_counter_out, 13'h0000)
  endtask
  task automatic test_prio();
    req(1'b1, 1'b1, 1'b1, 13'h0100);
    `CHK(program_counter_out, 13'h0004)
    req(1'b0, 1'b1, 1'b1, 13'h017F);
    `CHK({program_counter_out, high_endurance_region_out}, {13'h017F, 1'b0})
    `CHK({sm_fetch, sm_flag}, {8'h7F, 1'b0})
    req(1'b0, 1'b0, 1'b1, 13'h0000);
    `CHK(high_endurance_region_out, 1'b1)
    `CHK({sm_fetch, sm_flag}, {8'h80, 1'b1})
  endtask
  task automatic test_mem();
    wr(13'h0A10, 14'h2A5C);
    req(1'b0, 1'b1, 1'b0, 13'h0010);
    `CHK(instr_out, 14'h2A5C)
    wr(13'h0190, 14'h1234);
    req(1'b0, 1'b1, 1'b0, 13'h0190);
    `CHK(instr_out[7:0], 8'h34)
    hi_keep = instr_out[13:8];
    wr(13'h0190, 14'h2B56);
    req(1'b0, 1'b1, 1'b0, 13'h0190);
    `CHK(instr_out, {hi_keep, 8'h56})
    `CHK(instr_out[13:8] === 6'h2B, 1'b0)
  endtask
  initial begin
    {nrst_in, step_in, load_in, irq_take_in, wr_en_in} = 5'h00;
    {load_addr_in, wr_addr_in, wr_data_in} = 40'h0;
    repeat (12) tick();
    nrst_in = 1'b1;
    `CHK(program_counter_out, 13'h0000)
    test_wrap();
    test_prio();
    test_mem();
    test_reset();
    final_report();
  end
  initial begin
    repeat (500) @(posedge clock_in);
    failures++;
    final_report();
  end
endmodule // pma_addr_map_test
